// ==== rtl/src_pkg.sv ====
// Register map, field positions, reset values and states of the serial port
package src_pkg;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_DATA = 3'h2;
    localparam logic [2:0] ADDR_DIRECTION = 3'h3;
    localparam logic [2:0] ADDR_OPTIONS = 3'h4;

    localparam int CTL_IRQ_EN = 7;
    localparam int CTL_SYS_EN = 6;
    localparam int CTL_OPEN_DRAIN = 5;
    localparam int CTL_MASTER = 4;
    localparam int CTL_CLOCK_POLARITY = 3;
    localparam int CTL_CLOCK_PHASE = 2;
    localparam int CTL_RATE_HI = 1;
    localparam int CTL_RATE_LO = 0;

    localparam int STS_DONE = 7;
    localparam int STS_WRITE_COLLISION_FLAG = 6;
    localparam int STS_MODE_FAULT_FLAG = 4;

    localparam int OPT_LSB_FIRST = 6;
    localparam int OPT_PRESCALE = 5;

    // Pin vector index; direction bit of pin i is bit DIR_BASE + i
    localparam int PIN_SELECT = 3;
    localparam int PIN_SCK = 2;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 0;
    localparam int DIR_BASE = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] OPTIONS_RESET = 8'h00;
    localparam logic [7:0] DIR_SERIAL_MASK = 8'h3c;
    localparam logic [3:0] SYNC_RESET = 4'hc;

    // Half periods of the serial clock in bus clocks, before the prescaler
    localparam logic [6:0] HALF_RATE_0 = 7'h01;
    localparam logic [6:0] HALF_RATE_1 = 7'h02;
    localparam logic [6:0] HALF_RATE_2 = 7'h08;
    localparam logic [6:0] HALF_RATE_3 = 7'h10;
    localparam int PRESCALE_SHIFT = 2;
    localparam logic [3:0] LAST_EDGE = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } src_state_e;
endpackage

// ==== rtl/src_serial_port.sv ====
// Byte-wide synchronous serial port with control, status and data registers
//
// Functional notes
// - Interrupt request while enabled and transfer-done or mode-fault flag is set.
// - System enable hands the four port pins to the serial port; clear turns it off.
// - Open-drain select makes only the four serial pins open-drain.
// - Master select 0 is slave mode, 1 is master mode.
// - Master serial clock idles at the clock polarity level.
// - Clock phase with polarity picks the sample and launch edges.
// - Master rate bits divide bus clock by 2,4,16,32,8,16,64,128.
// - Rate bits have no effect in slave mode.
// - Prescale bit adds a divide-by-four stage to the rate chain.
// - Transfer-done flag sets at the end of every byte, master or slave.
// - Done flag clears on status read seeing it, then a data access.
// - Data write blocked while done flag set and not yet seen by status read.
// - Collision flag clears on status read seeing it, then a data access.
// - Mode-fault flag clears on status read seeing it, then a control write.
// - Only a data write in master mode starts a transfer.
// - Data writes load the transmit shifter; data reads return the receive buffer.
// - Master select-pin direction 0 is fault detect, 1 general output.
// - Serial inputs ignore direction bits; outputs drive only with direction set.
// - LSB-first option reverses shift order, register bit 7 stays the top.
// - Select low on a master clears master and serial directions, sets fault.
// - Data write during a transfer is dropped and sets the collision flag.
`timescale 1ns/1ps
module src_serial_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic select_pin_level,
    input wire logic [3:0] serial_port_pins_in,
    output logic [3:0] serial_port_pins_out,
    output logic [3:0] serial_port_pins_oe,
    output logic irq_request
);
    logic [7:0] control_reg;
    logic [7:0] direction_reg;
    logic [7:0] options_reg;
    logic [7:0] read_buf_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_next;
    logic [3:0] sync1_reg, sync2_reg, sync3_reg, pin_filt_reg;
    logic sck_prev_reg, sck_reg;
    logic [6:0] div_cnt_reg, half_len, half_base;
    logic [3:0] edge_cnt_reg;
    logic done_flag_reg, write_collision_flag_flag_reg, mode_fault_flag_flag_reg;
    logic done_seen_reg, write_collision_flag_seen_reg, mode_fault_flag_seen_reg;
    src_pkg::src_state_e state_reg;
    logic en, master, clock_phase, lsb_first, open_drain;
    logic acc_data, wr_data, rd_status, wr_control;
    logic busy, accept_wr, start, fault, slave_sel;
    logic m_edge, s_edge, edge_ev, sample_ev, launch_ev, done_ev;
    logic in_bit, tx_bit;
    logic done_clr, write_collision_flag_clr, mode_fault_flag_clr;
    logic [3:0] drive, val;

    assign en = control_reg[src_pkg::CTL_SYS_EN];
    assign master = control_reg[src_pkg::CTL_MASTER];
    assign clock_phase = control_reg[src_pkg::CTL_CLOCK_PHASE];
    assign open_drain = control_reg[src_pkg::CTL_OPEN_DRAIN];
    assign lsb_first = options_reg[src_pkg::OPT_LSB_FIRST];

    assign acc_data = (reg_wr || reg_rd) && reg_addr == src_pkg::ADDR_DATA;
    assign wr_data = reg_wr && reg_addr == src_pkg::ADDR_DATA;
    assign rd_status = reg_rd && reg_addr == src_pkg::ADDR_STATUS;
    assign wr_control = reg_wr && reg_addr == src_pkg::ADDR_CONTROL;

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= src_pkg::SYNC_RESET;
            sync2_reg <= src_pkg::SYNC_RESET;
            sync3_reg <= src_pkg::SYNC_RESET;
            pin_filt_reg <= src_pkg::SYNC_RESET;
        end else begin
            sync1_reg <= serial_port_pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_filt_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg)
                | ((sync2_reg ^ sync3_reg) & pin_filt_reg);
        end
    end

    // Mode fault only while the select pin is a fault-detect input
    assign fault = en && master && !direction_reg[src_pkg::DIR_BASE + src_pkg::PIN_SELECT]
        && !pin_filt_reg[src_pkg::PIN_SELECT];
    assign slave_sel = en && !master && !pin_filt_reg[src_pkg::PIN_SELECT];

    // Slave with phase 0 stays busy for as long as it is selected
    always_comb begin
        if (!en) begin
            busy = 1'b0;
        end else if (master) begin
            busy = state_reg == src_pkg::ST_RUN;
        end else if (clock_phase) begin
            busy = edge_cnt_reg != 4'h0;
        end else begin
            busy = !pin_filt_reg[src_pkg::PIN_SELECT];
        end
    end

    assign accept_wr = wr_data && !busy && !(done_flag_reg && !done_seen_reg);
    assign start = accept_wr && en && master && state_reg == src_pkg::ST_IDLE;

    // Rate chain is read only by the master divider, so slaves ignore it
    always_comb begin
        unique case (control_reg[src_pkg::CTL_RATE_HI:src_pkg::CTL_RATE_LO])
            2'b00: half_base = src_pkg::HALF_RATE_0;
            2'b01: half_base = src_pkg::HALF_RATE_1;
            2'b10: half_base = src_pkg::HALF_RATE_2;
            2'b11: half_base = src_pkg::HALF_RATE_3;
        endcase
        half_len = options_reg[src_pkg::OPT_PRESCALE]
            ? half_base << src_pkg::PRESCALE_SHIFT : half_base;
    end

    assign m_edge = state_reg == src_pkg::ST_RUN && div_cnt_reg == half_len - 7'h01;
    assign s_edge = slave_sel && pin_filt_reg[src_pkg::PIN_SCK] != sck_prev_reg;
    assign edge_ev = master ? m_edge : s_edge;
    assign sample_ev = edge_ev && (edge_cnt_reg[0] == clock_phase);
    assign launch_ev = edge_ev && (edge_cnt_reg[0] != clock_phase)
        && !(clock_phase && edge_cnt_reg == 4'h0);
    assign done_ev = edge_ev && edge_cnt_reg == src_pkg::LAST_EDGE;
    assign in_bit = master ? pin_filt_reg[src_pkg::PIN_MISO] : pin_filt_reg[src_pkg::PIN_MOSI];
    assign tx_bit = lsb_first ? tx_sh_reg[0] : tx_sh_reg[7];
    assign rx_next = lsb_first ? {in_bit, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], in_bit};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= src_pkg::ST_IDLE;
        end else if (!en || !master || fault || done_ev) begin
            state_reg <= src_pkg::ST_IDLE;
        end else if (start) begin
            state_reg <= src_pkg::ST_RUN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 7'h00;
            sck_reg <= 1'b0;
        end else if (state_reg != src_pkg::ST_RUN || start) begin
            div_cnt_reg <= 7'h00;
            sck_reg <= control_reg[src_pkg::CTL_CLOCK_POLARITY];
        end else if (m_edge) begin
            div_cnt_reg <= 7'h00;
            sck_reg <= !sck_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= pin_filt_reg[src_pkg::PIN_SCK];
        end
    end

    // Deselecting a slave drops any half-shifted byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_reg <= 4'h0;
        end else if (start || fault || !en || (!master && !slave_sel)) begin
            edge_cnt_reg <= 4'h0;
        end else if (edge_ev) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_reg <= 8'h00;
        end else if (accept_wr) begin
            tx_sh_reg <= reg_wdata;
        end else if (launch_ev) begin
            tx_sh_reg <= lsb_first ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_reg <= 8'h00;
        end else if (sample_ev) begin
            rx_sh_reg <= rx_next;
        end
    end

    // No overrun guard: an unread byte is overwritten by the next one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_buf_reg <= 8'h00;
        end else if (done_ev) begin
            read_buf_reg <= sample_ev ? rx_next : rx_sh_reg;
        end
    end

    assign done_clr = done_seen_reg && acc_data;
    assign write_collision_flag_clr = write_collision_flag_seen_reg && acc_data;
    assign mode_fault_flag_clr = mode_fault_flag_seen_reg && wr_control;

    // Flags: a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else begin
            if (done_ev) begin
                done_flag_reg <= 1'b1;
            end else if (done_clr) begin
                done_flag_reg <= 1'b0;
            end
            if (done_clr) begin
                done_seen_reg <= 1'b0;
            end else if (rd_status && done_flag_reg) begin
                done_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_collision_flag_flag_reg <= 1'b0;
            write_collision_flag_seen_reg <= 1'b0;
        end else begin
            if (wr_data && busy) begin
                write_collision_flag_flag_reg <= 1'b1;
            end else if (write_collision_flag_clr) begin
                write_collision_flag_flag_reg <= 1'b0;
            end
            if (write_collision_flag_clr) begin
                write_collision_flag_seen_reg <= 1'b0;
            end else if (rd_status && write_collision_flag_flag_reg) begin
                write_collision_flag_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_fault_flag_flag_reg <= 1'b0;
            mode_fault_flag_seen_reg <= 1'b0;
        end else begin
            if (fault) begin
                mode_fault_flag_flag_reg <= 1'b1;
            end else if (mode_fault_flag_clr) begin
                mode_fault_flag_flag_reg <= 1'b0;
            end
            if (mode_fault_flag_clr) begin
                mode_fault_flag_seen_reg <= 1'b0;
            end else if (rd_status && mode_fault_flag_flag_reg) begin
                mode_fault_flag_seen_reg <= 1'b1;
            end
        end
    end

    // A fault overrides a control or direction write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= src_pkg::CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= reg_wdata;
            end
            if (fault) begin
                control_reg[src_pkg::CTL_MASTER] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_reg <= src_pkg::DIRECTION_RESET;
        end else if (fault) begin
            direction_reg <= (reg_wr && reg_addr == src_pkg::ADDR_DIRECTION ? reg_wdata
                : direction_reg) & ~src_pkg::DIR_SERIAL_MASK;
        end else if (reg_wr && reg_addr == src_pkg::ADDR_DIRECTION) begin
            direction_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            options_reg <= src_pkg::OPTIONS_RESET;
        end else if (reg_wr && reg_addr == src_pkg::ADDR_OPTIONS) begin
            options_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                src_pkg::ADDR_CONTROL: reg_rdata <= control_reg;
                src_pkg::ADDR_STATUS: reg_rdata <= {done_flag_reg, write_collision_flag_flag_reg, 1'b0,
                    mode_fault_flag_flag_reg, 4'h0};
                src_pkg::ADDR_DATA: reg_rdata <= read_buf_reg;
                src_pkg::ADDR_DIRECTION: reg_rdata <= direction_reg;
                src_pkg::ADDR_OPTIONS: reg_rdata <= options_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Pin drivers: outputs need their direction bit, inputs do not
    always_comb begin
        drive[src_pkg::PIN_SELECT] = en && master
            && direction_reg[src_pkg::DIR_BASE + src_pkg::PIN_SELECT];
        drive[src_pkg::PIN_SCK] = en && master
            && direction_reg[src_pkg::DIR_BASE + src_pkg::PIN_SCK];
        drive[src_pkg::PIN_MOSI] = en && master
            && direction_reg[src_pkg::DIR_BASE + src_pkg::PIN_MOSI];
        drive[src_pkg::PIN_MISO] = slave_sel
            && direction_reg[src_pkg::DIR_BASE + src_pkg::PIN_MISO];
        val[src_pkg::PIN_SELECT] = select_pin_level;
        val[src_pkg::PIN_SCK] = sck_reg;
        val[src_pkg::PIN_MOSI] = tx_bit;
        val[src_pkg::PIN_MISO] = tx_bit;
    end

    assign serial_port_pins_out = open_drain ? 4'h0 : val;
    assign serial_port_pins_oe = open_drain ? (drive & ~val) : drive;
    assign irq_request = control_reg[src_pkg::CTL_IRQ_EN]
        && (done_flag_reg || mode_fault_flag_flag_reg);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_done_seen;
        rd_status && done_flag_reg;
    endsequence
    sequence s_data_access;
        acc_data && !done_ev;
    endsequence

    property p_irq;
        $rose(done_flag_reg || mode_fault_flag_flag_reg) && control_reg[src_pkg::CTL_IRQ_EN]
            |-> irq_request;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_off;
        !en |-> serial_port_pins_oe == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("pin driven while off");

    property p_open_drain;
        open_drain |-> (serial_port_pins_out | (serial_port_pins_oe & val)) == 4'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_idle_level;
        state_reg == src_pkg::ST_IDLE ##1 state_reg == src_pkg::ST_IDLE
            |-> sck_reg == $past(control_reg[src_pkg::CTL_CLOCK_POLARITY]);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock idle level");

    property p_rate;
        state_reg == src_pkg::ST_RUN && $changed(sck_reg) && !$past(start)
            |-> $past(div_cnt_reg) == $past(half_len) - 7'h01;
    endproperty
    a_rate: assert property (p_rate) else $error("clock divide wrong");

    property p_done;
        done_ev |=> done_flag_reg && read_buf_reg == $past(sample_ev ? rx_next : rx_sh_reg);
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");

    property p_done_clear;
        s_done_seen ##[1:3] s_data_access |=> !done_flag_reg;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag stuck");

    property p_blocked;
        wr_data && done_flag_reg && !done_seen_reg |=> $stable(tx_sh_reg) || $past(launch_ev);
    endproperty
    a_blocked: assert property (p_blocked) else $error("write not blocked");

    property p_collision;
        // A transfer that ends or faults in the write cycle may change state legally
        wr_data && busy && !done_ev && !fault |=> write_collision_flag_flag_reg
            && state_reg == $past(state_reg);
    endproperty
    a_collision: assert property (p_collision) else $error("collision missed");

    property p_fault;
        fault |=> mode_fault_flag_flag_reg && !master
            && (direction_reg & src_pkg::DIR_SERIAL_MASK) == 8'h00;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled");

    property p_mode_fault_flag_clear;
        rd_status && mode_fault_flag_flag_reg ##[1:3] wr_control && !fault |=> !mode_fault_flag_flag_reg;
    endproperty
    a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("fault flag stuck");

    property p_slave_idle;
        !master |=> state_reg == src_pkg::ST_IDLE;
    endproperty
    a_slave_idle: assert property (p_slave_idle) else $error("slave started");
endmodule

// ==== sim/src_far_slave.sv ====
// Far-side serial slave model that answers a master transfer
`timescale 1ns/1ps
module src_far_slave (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic clock_phase,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic miso_oe,
    output logic [7:0] rx_byte
);
    int edges;
    logic sck_seen;
    function automatic int pos(input int b);
        return lsb_first ? b : 7 - b;
    endfunction
    // Released when not selected; the pull-up then owns the line
    assign miso_oe = !sel_n;
    // One process owns the model state; while deselected it rewinds and preloads bit one
    // Reacts in zero time so the launched bit is settled long before the next edge
    always @(sck or sel_n or tx_byte or lsb_first) begin
        if (sel_n) begin
            edges = 0;
            miso = tx_byte[pos(0)];
        end else if (sck !== sck_seen) begin
            edges++;
            if ((edges % 2 == 1) != clock_phase) begin
                rx_byte[pos((edges - 1) / 2)] = mosi;
            end else if ((clock_phase ? (edges - 1) / 2 : edges / 2) < 8) begin
                miso = tx_byte[pos(clock_phase ? (edges - 1) / 2 : edges / 2)];
            end
        end
        sck_seen = sck;
    end
endmodule

// ==== sim/src_serial_port_tb.sv ====
// Self-checking bench for the serial port registers and master link
`timescale 1ns/1ps
module src_serial_port_tb;
    localparam logic [2:0] A_CTL = src_pkg::ADDR_CONTROL;
    localparam logic [2:0] A_STS = src_pkg::ADDR_STATUS;
    localparam logic [2:0] A_DAT = src_pkg::ADDR_DATA;
    localparam logic [2:0] A_DIR = src_pkg::ADDR_DIRECTION;
    localparam logic [2:0] A_OPT = src_pkg::ADDR_OPTIONS;
    localparam int DIV[8] = '{2, 4, 16, 32, 8, 16, 64, 128};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic select_pin_level = 1'b1;
    logic ss_in = 1'b1;
    logic sel_n = 1'b1;
    logic clock_phase = 1'b0;
    logic lsb = 1'b0;
    logic [7:0] ptx = 8'h00;
    logic [3:0] p_out;
    logic [3:0] p_oe;
    logic irq;
    logic s_miso;
    logic s_oe;
    logic [7:0] s_rx;
    logic [7:0] got;
    wire logic sel_w;
    wire logic sck_w;
    wire logic mosi_w;
    wire logic miso_w;
    int num_errors = 0;
    int checks_done = 0;
    int c;

    always #12.5 sys_clk = ~sys_clk;
    // Pull-ups on SCK, MOSI and MISO: a released line reads high, as open drain needs; a released select reads ss_in
    assign sel_w = p_oe[3] ? p_out[3] : ss_in;
    assign sck_w = p_oe[2] ? p_out[2] : 1'b1;
    assign mosi_w = p_oe[1] ? p_out[1] : 1'b1;
    assign miso_w = p_oe[0] ? p_out[0] : (s_oe ? s_miso : 1'b1);

    src_serial_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .select_pin_level(select_pin_level),
        .serial_port_pins_in({sel_w, sck_w, mosi_w, miso_w}),
        .serial_port_pins_out(p_out), .serial_port_pins_oe(p_oe), .irq_request(irq));
    src_far_slave far (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .clock_phase(clock_phase),
        .lsb_first(lsb), .tx_byte(ptx), .miso(s_miso), .miso_oe(s_oe), .rx_byte(s_rx));

    task automatic conclude();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Ends 1 ns after the taking edge so outputs driven from registers have settled
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        chk(got, e);
    endtask
    // Counts serial clock changes; c holds the cycles since the call started
    task automatic wait_sck(input int n);
        int k;
        logic p;
        k = 0;
        c = 0;
        p = sck_w;
        while (k < n) begin
            @(posedge sys_clk);
            #1;
            c++;
            if (sck_w !== p) begin
                k++;
                p = sck_w;
            end
            if (c > 4000) begin
                num_errors++;
                conclude();
            end
        end
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            chk_reg(3'(a), 8'h00);
        wr(3'h5, 8'hff);
        chk_reg(3'h5, 8'h00);
        wr(A_CTL, 8'h0f);
        chk_reg(A_CTL, 8'h0f);
        for (int m = 0; m < 8; m++) begin
            clock_phase <= m[0];
            lsb <= m[2];
            ptx <= 8'h3a ^ 8'(m * 37);
            wr(A_OPT, {1'b0, m[2], 6'h00});
            wr(A_DIR, 8'h1c);
            wr(A_CTL, {4'h5, m[1], m[0], 2'b10});
            // The idle clock level follows polarity one cycle after the write
            repeat (2) @(negedge sys_clk);
            chk(sck_w, m[1]);
            sel_n <= 1'b0;
            wr(A_DAT, 8'hc6 ^ 8'(m));
            wait_sck(16);
            repeat (2) @(negedge sys_clk);
            chk(sck_w, m[1]);
            chk(irq, 1'b0);
            chk(s_rx, 8'hc6 ^ 8'(m));
            // Written before the flag was seen: must neither start nor flag
            wr(A_DAT, 8'hff);
            repeat (20) @(negedge sys_clk);
            chk(sck_w, m[1]);
            chk_reg(A_STS, 8'h80);
            chk_reg(A_DAT, 8'h3a ^ 8'(m * 37));
            chk_reg(A_STS, 8'h00);
            sel_n <= 1'b1;
        end
        clock_phase <= 1'b0;
        lsb <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            wr(A_OPT, {2'b00, r[2], 5'h00});
            wr(A_CTL, {6'h34, r[1:0]});
            wr(A_DAT, 8'h5a);
            wait_sck(1);
            wait_sck(1);
            chk(8'(c), 8'(DIV[r] / 2));
            wait_sck(14);
            repeat (2) @(negedge sys_clk);
            chk(irq, 1'b1);
            rd(A_STS);
            rd(A_DAT);
            chk(irq, 1'b0);
        end
        wr(A_CTL, 8'h52);
        sel_n <= 1'b0;
        wr(A_DAT, 8'ha5);
        wait_sck(4);
        wr(A_DAT, 8'h0f);
        wait_sck(12);
        repeat (2) @(negedge sys_clk);
        chk(s_rx, 8'ha5);
        chk_reg(A_STS, 8'hc0);
        rd(A_DAT);
        chk_reg(A_STS, 8'h00);
        sel_n <= 1'b1;
        wr(A_DIR, 8'hff);
        select_pin_level <= 1'b0;
        ss_in <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({p_oe[3], p_out[3]}, 2'b10);
        chk_reg(A_STS, 8'h00);
        wr(A_DIR, 8'hdf);
        repeat (8) @(posedge sys_clk);
        chk_reg(A_STS, 8'h10);
        chk_reg(A_CTL, 8'h42);
        chk_reg(A_DIR, 8'hc3);
        chk(irq, 1'b0);
        ss_in <= 1'b1;
        rd(A_DAT);
        chk_reg(A_STS, 8'h10);
        wr(A_CTL, 8'h00);
        chk_reg(A_STS, 8'h00);
        chk(p_oe, 4'h0);
        wr(A_DIR, 8'h1c);
        wr(A_CTL, 8'h78);
        repeat (2) @(negedge sys_clk);
        chk(p_oe[2], 1'b0);
        wr(A_CTL, 8'h70);
        repeat (2) @(negedge sys_clk);
        chk({p_oe[2], p_out[2]}, 2'b10);
        wr(A_DIR, 8'h00);
        chk(p_oe[2:1], 2'b00);
        wr(A_CTL, 8'h43);
        wr(A_DIR, 8'h1c);
        wr(A_DAT, 8'h11);
        repeat (40) @(negedge sys_clk);
        chk(p_oe[2], 1'b0);
        chk_reg(A_STS, 8'h00);
        conclude();
    end
endmodule
